// ---- common/bpc_pkg.sv ----
// Package with register map, field positions and reset values of the bank.
package bpc_pkg;
    // Printed offsets are register indices, not byte offsets: each byte address is four times its index.
    localparam logic [15:0] IDX_TYPE_CODE = 16'h1007;
    localparam logic [15:0] IDX_TX_DISABLE = 16'h1009;
    localparam logic [15:0] IDX_EXT_ABILITY2 = 16'h100B;
    localparam logic [15:0] IDX_SPEED_ABILITY = 16'h1012;
    localparam logic [15:0] IDX_ROLE_SPEED = 16'h1834;
    localparam int ADDR_W = 18;
    localparam int TYPE_LSB = 0;
    localparam int TYPE_W = 6;
    localparam int TXDIS_BIT = 0;
    localparam int EXTRA_BIT = 11;
    localparam int GIG_BIT = 1;
    localparam int FAST_BIT = 0;
    localparam int ROLE_BIT = 14;
    localparam int ROLE_RSVD_BIT = 15;
    localparam int SPEED_LSB = 0;
    localparam int SPEED_W = 4;
    localparam logic [15:0] RST_TYPE_CODE = 16'h003D;
    localparam logic [15:0] RST_TX_DISABLE = 16'h0000;
    localparam logic [15:0] RST_EXT_ABILITY2 = 16'h0800;
    localparam logic [15:0] RST_SPEED_ABILITY = 16'h0002;
    localparam logic [15:0] RST_ROLE_SPEED = 16'h8001;
    localparam logic [3:0] SPEED_100 = 4'h0;
    localparam logic [3:0] SPEED_1000 = 4'h1;
    // Register select codes produced by the address decoder.
    typedef enum logic [2:0] {
        BPC_SEL_NONE,
        BPC_SEL_TYPE,
        BPC_SEL_TXDIS,
        BPC_SEL_EXT2,
        BPC_SEL_ABIL,
        BPC_SEL_ROLE
    } bpc_sel_t;
endpackage

// ---- rtl/bpc_addr_decode.sv ----
// Address decoder mapping an APB byte address to a register select.
`timescale 1ns/1ps
`default_nettype none
module bpc_addr_decode
    import bpc_pkg::*;
(
    // Bus address
    input wire logic [ADDR_W-1:0] paddr,
    // Decoded select
    output bpc_sel_t sel
);
    logic [15:0] idx;
    assign idx = paddr[ADDR_W-1:2];
    always_comb begin
        if (paddr[1:0] != 2'h0) begin
            sel = BPC_SEL_NONE;
        end else begin
            case (idx)
                IDX_TYPE_CODE: sel = BPC_SEL_TYPE;
                IDX_TX_DISABLE: sel = BPC_SEL_TXDIS;
                IDX_EXT_ABILITY2: sel = BPC_SEL_EXT2;
                IDX_SPEED_ABILITY: sel = BPC_SEL_ABIL;
                IDX_ROLE_SPEED: sel = BPC_SEL_ROLE;
                default: sel = BPC_SEL_NONE;
            endcase
        end
    end
endmodule // bpc_addr_decode
`default_nettype wire

// ---- rtl/bpc_regs.sv ----
// Medium-attachment configuration and ability register bank with APB slave.
//
// Operation
// - Six-bit writable type field, resets 111101
// - Type register reads 0x3D after reset
// - Transmit-disable bit zero writable, resets zero
// - Extended-ability2 bit 11 always reads one
// - Ability bit 1 reads one, gigabit
// - Ability bit 0 reads zero, no fast
// - Bit 14 selects master or slave
// - Bits 3-0 select speed, reset 0001
// - Role register resets 0x8001, bit15 one
`timescale 1ns/1ps
`default_nettype none
module bpc_regs
    import bpc_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Configuration outputs to the transceiver
    output logic [TYPE_W-1:0] type_select,
    output logic transmit_disable,
    output logic role_master,
    output logic [SPEED_W-1:0] speed_select,
    // Ability flags
    output logic has_extra_abilities,
    output logic gigabit_capable,
    output logic fast_capable
);
    bpc_sel_t sel;
    logic [TYPE_W-1:0] type_reg;
    logic txdis_reg;
    logic role_reg;
    logic [SPEED_W-1:0] speed_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [15:0] rd_next;
    logic setup;
    logic wr_lo;
    logic wr_hi;

    bpc_addr_decode bpc_addr_decode_i (
        .paddr(paddr),
        .sel(sel)
    );

    // The answer comes one cycle after the setup cycle, so every access
    // takes exactly two cycles; the write commits at the access edge.
    assign setup = psel && !penable;
    assign wr_lo = psel && penable && pready_reg && pwrite && pstrb[0];
    assign wr_hi = psel && penable && pready_reg && pwrite && pstrb[1];

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            type_reg <= RST_TYPE_CODE[TYPE_LSB +: TYPE_W];
        end else if (wr_lo && sel == BPC_SEL_TYPE) begin
            type_reg <= pwdata[TYPE_LSB +: TYPE_W];
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            txdis_reg <= RST_TX_DISABLE[TXDIS_BIT];
        end else if (wr_lo && sel == BPC_SEL_TXDIS) begin
            txdis_reg <= pwdata[TXDIS_BIT];
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            role_reg <= RST_ROLE_SPEED[ROLE_BIT];
        end else if (wr_hi && sel == BPC_SEL_ROLE) begin
            role_reg <= pwdata[ROLE_BIT];
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            speed_reg <= RST_ROLE_SPEED[SPEED_LSB +: SPEED_W];
        end else if (wr_lo && sel == BPC_SEL_ROLE) begin
            speed_reg <= pwdata[SPEED_LSB +: SPEED_W];
        end
    end

    // Read image: only storage bits come from flops, others are constants.
    always_comb begin
        rd_next = 16'h0000;
        case (sel)
            BPC_SEL_TYPE: begin
                rd_next = RST_TYPE_CODE;
                rd_next[TYPE_LSB +: TYPE_W] = type_reg;
            end
            BPC_SEL_TXDIS: begin
                rd_next = RST_TX_DISABLE;
                rd_next[TXDIS_BIT] = txdis_reg;
            end
            BPC_SEL_EXT2: begin
                rd_next = RST_EXT_ABILITY2;
            end
            BPC_SEL_ABIL: begin
                rd_next = RST_SPEED_ABILITY;
            end
            BPC_SEL_ROLE: begin
                rd_next = RST_ROLE_SPEED;
                rd_next[ROLE_BIT] = role_reg;
                rd_next[SPEED_LSB +: SPEED_W] = speed_reg;
            end
            default: begin
                rd_next = 16'h0000;
            end
        endcase
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pready_reg <= 1'b0;
        end else begin
            pready_reg <= setup;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            prdata_reg <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            prdata_reg <= {16'h0000, rd_next};
        end else if (setup) begin
            prdata_reg <= 32'h0000_0000;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pslverr_reg <= 1'b0;
        end else if (setup) begin
            pslverr_reg <= (sel == BPC_SEL_NONE);
        end else begin
            pslverr_reg <= 1'b0;
        end
    end

    // Flag outputs are registered copies of the fixed ability bits.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            has_extra_abilities <= 1'b0;
            gigabit_capable <= 1'b0;
            fast_capable <= 1'b0;
        end else begin
            has_extra_abilities <= RST_EXT_ABILITY2[EXTRA_BIT];
            gigabit_capable <= RST_SPEED_ABILITY[GIG_BIT];
            fast_capable <= RST_SPEED_ABILITY[FAST_BIT];
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign type_select = type_reg;
    assign transmit_disable = txdis_reg;
    assign role_master = role_reg;
    assign speed_select = speed_reg;
endmodule // bpc_regs
`default_nettype wire

// ---- testbench/bpc_monitor.sv ----
// Checker and bind for the configuration register bank.
`timescale 1ns/1ps
`default_nettype none
module bpc_monitor
    import bpc_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Fields
    input wire logic [TYPE_W-1:0] type_select,
    input wire logic transmit_disable,
    input wire logic role_master,
    input wire logic [SPEED_W-1:0] speed_select,
    input wire logic has_extra_abilities,
    input wire logic gigabit_capable,
    input wire logic fast_capable
);
    localparam logic [ADDR_W-1:0] A_TYPE = {IDX_TYPE_CODE, 2'b00};
    localparam logic [ADDR_W-1:0] A_TXDIS = {IDX_TX_DISABLE, 2'b00};
    localparam logic [ADDR_W-1:0] A_ROLE = {IDX_ROLE_SPEED, 2'b00};
    logic acc;
    logic wr;
    assign acc = psel && penable && pready;
    assign wr = acc && pwrite && !pslverr;
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    type_read_a: assert property (
        acc && !pwrite && paddr == A_TYPE |->
        prdata == {26'h0, type_select}) else $error("type bad");
    reset_val_a: assert property (
        $rose(reset_n) |-> type_select == 6'h3D
        && speed_select == 4'h1 && !role_master) else $error("reset bad");
    txdis_wr_a: assert property (
        wr && paddr == A_TXDIS && pstrb[0] |=>
        transmit_disable == $past(pwdata[0])) else $error("txdis bad");
    ability_a: assert property (
        $past(reset_n) |-> gigabit_capable
        && has_extra_abilities && !fast_capable) else $error("flags bad");
    role_wr_a: assert property (
        wr && paddr == A_ROLE && pstrb[1] |=>
        role_master == $past(pwdata[14])) else $error("role bad");
    speed_wr_a: assert property (
        wr && paddr == A_ROLE && pstrb[0] |=>
        speed_select == $past(pwdata[3:0])) else $error("speed bad");
    role_read_a: assert property (
        acc && !pwrite && paddr == A_ROLE |->
        prdata == {16'h0000, 1'b1, role_master, 10'h000, speed_select})
        else $error("rd bad");
    err_keep_a: assert property (
        acc && pslverr |=> $stable(type_select)
        && $stable(role_master)) else $error("error write bad");
    cover property (wr && paddr == A_ROLE);
    cover property (acc && pslverr);
    cover property (wr && paddr == A_TXDIS);
endmodule // bpc_monitor
bind bpc_regs bpc_monitor bpc_monitor_i (.clock, .reset_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .type_select, .transmit_disable, .role_master, .speed_select,
    .has_extra_abilities, .gigabit_capable, .fast_capable);
`default_nettype wire

// ---- testbench/testbench.sv ----
// Self-checking bench for the configuration register bank.
`timescale 1ns/1ps
`default_nettype none
module testbench
    import bpc_pkg::*;
;
    logic clock = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr, transmit_disable, role_master;
    logic has_extra_abilities, gigabit_capable, fast_capable, rerr;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic [3:0] pstrb = 4'h0;
    logic [TYPE_W-1:0] type_select;
    logic [SPEED_W-1:0] speed_select;
    int err_total = 0, checked = 0, cyc = 0;
    always #5 clock = ~clock;
    bpc_regs bpc_regs_i (.clock, .reset_n, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .prdata, .pready, .pslverr, .type_select,
        .transmit_disable, .role_master, .speed_select, .has_extra_abilities,
        .gigabit_capable, .fast_capable);
    task automatic chk(input logic [32:0] g, input logic [32:0] e);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic xfer(input logic w, input logic [17:0] a,
            input logic [31:0] d, input logic [3:0] s);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [17:0] a, input logic [32:0] e);
        xfer(1'b0, a, 32'h0, 4'h0);
        chk({rerr, rdat}, e);
    endtask
    task automatic t_reset;
        rd(18'h0401C, 33'h3D);
        rd(18'h04024, 33'h0);
        rd(18'h0402C, 33'h800);
        rd(18'h04048, 33'h2);
        rd(18'h060D0, 33'h8001);
        chk({22'h0, type_select, speed_select, role_master}, 33'h7A2);
        chk({29'h0, transmit_disable, has_extra_abilities, gigabit_capable,
            fast_capable}, 33'h6);
        $display("reset test done");
    endtask
    task automatic t_write;
        xfer(1'b1, 18'h0401C, 32'hFFFFFFFF, 4'hF);
        xfer(1'b1, 18'h04024, 32'hFFFFFFFF, 4'hF);
        xfer(1'b1, 18'h0402C, 32'hFFFFFFFF, 4'hF);
        xfer(1'b1, 18'h04048, 32'hFFFFFFFF, 4'hF);
        xfer(1'b1, 18'h060D0, 32'hFFFFFFFF, 4'hF);
        rd(18'h0401C, 33'h3F);
        rd(18'h04024, 33'h1);
        rd(18'h0402C, 33'h800);
        rd(18'h04048, 33'h2);
        rd(18'h060D0, 33'hC00F);
        xfer(1'b1, 18'h060D0, 32'h0, 4'h1);
        rd(18'h060D0, 33'hC000);
        xfer(1'b1, 18'h060D0, 32'h0, 4'h2);
        rd(18'h060D0, 33'h8000);
        xfer(1'b1, 18'h060D0, 32'h1, 4'hF);
        @(posedge clock);
        chk({28'h0, role_master, speed_select}, 33'h1);
        chk({32'h0, transmit_disable}, 33'h1);
        xfer(1'b1, 18'h04024, 32'h0, 4'h1);
        @(posedge clock);
        chk({32'h0, transmit_disable}, 33'h0);
        $display("write test done");
    endtask
    task automatic t_err;
        rd(18'h0401D, 33'h100000000);
        xfer(1'b1, 18'h0401D, 32'h0, 4'hF);
        chk({32'h0, rerr}, 33'h1);
        rd(18'h0401C, 33'h3F);
        $display("error test done");
    endtask
    task automatic t_rerst;
        xfer(1'b1, 18'h04024, 32'h1, 4'h1);
        @(posedge clock);
        reset_n <= 1'b0;
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        rd(18'h0401C, 33'h3D);
        rd(18'h04024, 33'h0);
        rd(18'h060D0, 33'h8001);
        $display("second reset test done");
    endtask
    task automatic wrap_up;
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            err_total++;
            wrap_up();
        end
    end
    initial begin
        repeat (8) @(posedge clock);
        reset_n <= 1'b1;
        t_reset();
        t_write();
        t_err();
        t_rerst();
        wrap_up();
    end
endmodule // testbench
`default_nettype wire
